// ==== design/load_remote_command_port.sv ====
// remote command interpreter: serial frames, staged setpoints, command apply
// Function
// - command 38 applies setpoint, end voltage; battery test
// - command 25 applies dynamic parameters, mode 0..2
// - command 41 applies limits and remote enable
// - only matching rate and address frames answered
// - rates 4800/9600/19200/38400, 9600 after reset
// - 8 data bits, 1 stop, parity none/even/odd
// - rate and address set locally or remotely
// - command 42 input on, 43 input off
// - remote coil 1 enters, 0 leaves remote control
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module load_remote_command_port #(parameter int CLK_FREQ = load_remote_pkg::CLK_HZ) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // serial pins
   input wire logic rxdPin,
   output logic txdPin,
   // local register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   // state toward the load
   output logic [load_remote_pkg::PARAM_COUNT-1:0][31:0] activeParam,
   output load_remote_pkg::load_state_s loadState,
   output load_remote_pkg::serial_cfg_s serialCfg
);
   import load_remote_pkg::*;
   typedef enum logic [2:0] {S_COLLECT, S_DECODE, S_WRITE, S_APPLY, S_REPLY} state_e;
   state_e state_reg;
   logic rxMeta_reg, rxSync_reg;
   logic rxValid, rxError, txReady, txStart_reg, txWait_reg;
   logic [7:0] rxByte, txByte_reg;
   logic [7:0] buf_reg [RX_BUF_BYTES];
   logic [4:0] count_reg, idx_reg;
   logic [15:0] crc_reg, txCrc_reg, gapTick_reg, cmd_reg, bitTicks;
   logic [5:0] gapBits_reg;
   logic bad_reg, cmdSeen_reg;
   logic [PARAM_COUNT-1:0][31:0] staged_reg;
   logic stagedEnable_reg, cfgPend_reg, cfgApply;
   serial_cfg_s cfgStaged_reg;
   logic [31:0] errors_reg;
   logic frameDone, frameOk, coilOk, presetOk, writeEn, applyEn;
   logic [15:0] startAddr, wordAt, nRegs, curAddr, curVal;

   assign bitTicks = bit_ticks(serialCfg.baudSel, CLK_FREQ);
   assign startAddr = {buf_reg[2], buf_reg[3]};
   assign wordAt = {buf_reg[4], buf_reg[5]};
   assign nRegs = wordAt;
   assign curAddr = startAddr + 16'(idx_reg);
   assign curVal = {buf_reg[5'd7 + {idx_reg[3:0], 1'b0}], buf_reg[5'd8 + {idx_reg[3:0], 1'b0}]};
   assign frameDone = state_reg == S_COLLECT && count_reg != 5'h0 && gapBits_reg == 6'(GAP_BITS);
   // address filter and check sum; a wrong rate shows as bad characters
   assign frameOk = !bad_reg && count_reg >= 5'd8 && crc_reg == 16'h0000
                    && buf_reg[0] == serialCfg.devAddr;
   assign coilOk = buf_reg[1] == FN_FORCE_COIL && count_reg == 5'd8
                   && (wordAt == COIL_ON || wordAt == COIL_OFF);
   assign presetOk = buf_reg[1] == FN_PRESET_MULTI && nRegs != 16'h0000
                     && nRegs <= 16'(MAX_PRESET_REGS) && {8'h00, buf_reg[6]} == nRegs << 1
                     && {11'h000, count_reg} == 16'd9 + (nRegs << 1);
   assign writeEn = state_reg == S_WRITE;
   assign applyEn = state_reg == S_APPLY && cmdSeen_reg;
   assign cfgApply = state_reg == S_REPLY && txReady && !txWait_reg && idx_reg == 5'd8;

   // pin synchroniser
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         rxMeta_reg <= 1'b1;
         rxSync_reg <= 1'b1;
      end else begin
         rxMeta_reg <= rxdPin;
         rxSync_reg <= rxMeta_reg;
      end
   end

   uart_rx_unit rxUnit (
      .ref_clk(ref_clk), .resetn(resetn), .rxLine(rxSync_reg), .bitTicks(bitTicks),
      .parity(serialCfg.parity), .byteValid(rxValid), .byteData(rxByte), .byteError(rxError)
   );
   uart_tx_unit txUnit (
      .ref_clk(ref_clk), .resetn(resetn), .txStart(txStart_reg), .txData(txByte_reg),
      .txReady(txReady), .bitTicks(bitTicks), .parity(serialCfg.parity), .txLine(txdPin)
   );

   // silence timer marking the end of a frame
   always_ff @(posedge ref_clk) begin
      if (!resetn || !rxSync_reg || rxValid || state_reg != S_COLLECT) begin
         gapTick_reg <= 16'h0000;
         gapBits_reg <= 6'h00;
      end else if (gapBits_reg != 6'(GAP_BITS)) begin
         if (gapTick_reg == bitTicks - 16'h0001) begin
            gapTick_reg <= 16'h0000;
            gapBits_reg <= gapBits_reg + 6'h01;
         end else begin
            gapTick_reg <= gapTick_reg + 16'h0001;
         end
      end
   end

   // frame collection, decode, register walk and reply sequencing
   always_ff @(posedge ref_clk) begin
      txStart_reg <= 1'b0;
      if (!resetn) begin
         state_reg <= S_COLLECT;
         count_reg <= 5'h0;
         idx_reg <= 5'h0;
         crc_reg <= 16'hFFFF;
         txCrc_reg <= 16'hFFFF;
         bad_reg <= 1'b0;
         txWait_reg <= 1'b0;
         txByte_reg <= 8'h00;
         for (int i = 0; i < RX_BUF_BYTES; i++) buf_reg[i] <= 8'h00;
      end else begin
         unique case (state_reg)
            S_COLLECT: begin
               if (rxValid) begin
                  bad_reg <= bad_reg | rxError | (count_reg == 5'(RX_BUF_BYTES));
                  if (count_reg != 5'(RX_BUF_BYTES)) begin
                     buf_reg[count_reg] <= rxByte;
                     count_reg <= count_reg + 5'h1;
                     crc_reg <= crc_step(crc_reg, rxByte);
                  end
               end else if (frameDone) begin
                  state_reg <= S_DECODE;
               end
            end
            S_DECODE: begin
               idx_reg <= 5'h0;
               txCrc_reg <= 16'hFFFF;
               if (frameOk && presetOk) state_reg <= S_WRITE;
               else if (frameOk && coilOk) state_reg <= S_REPLY;
               else state_reg <= S_COLLECT;
               count_reg <= 5'h0;
               crc_reg <= 16'hFFFF;
               bad_reg <= 1'b0;
            end
            S_WRITE: begin
               idx_reg <= idx_reg + 5'h1;
               if ({11'h000, idx_reg} == nRegs - 16'h0001) state_reg <= S_APPLY;
            end
            S_APPLY: begin
               idx_reg <= 5'h0;
               state_reg <= S_REPLY;
            end
            S_REPLY: begin
               // echo the first six bytes, then the check sum
               if (txWait_reg) begin
                  txWait_reg <= 1'b0;
               end else if (txReady) begin
                  if (idx_reg == 5'd8) begin
                     state_reg <= S_COLLECT;
                  end else begin
                     txByte_reg <= idx_reg < 5'd6 ? buf_reg[idx_reg[2:0]]
                                 : idx_reg == 5'd6 ? txCrc_reg[7:0] : txCrc_reg[15:8];
                     if (idx_reg < 5'd6) txCrc_reg <= crc_step(txCrc_reg, buf_reg[idx_reg[2:0]]);
                     txStart_reg <= 1'b1;
                     txWait_reg <= 1'b1;
                     idx_reg <= idx_reg + 5'h1;
                  end
               end
            end
            default: state_reg <= S_COLLECT;
         endcase
      end
   end

   // staged presets, command latch and staged serial setup
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         staged_reg <= '0;
         cmd_reg <= 16'h0000;
         cmdSeen_reg <= 1'b0;
         cfgStaged_reg <= CFG_RESET;
         cfgPend_reg <= 1'b0;
      end else if (state_reg == S_DECODE) begin
         cmdSeen_reg <= 1'b0;
         cfgPend_reg <= 1'b0;
      end else if (writeEn) begin
         if (curAddr < REG_PARAM_END) begin
            if (curAddr[4:1] != SLOT_MODE_SELECT) begin
               if (curAddr[0]) staged_reg[curAddr[4:1]][15:0] <= curVal;
               else staged_reg[curAddr[4:1]][31:16] <= curVal;
            end else if (curAddr[0] && curVal <= MAX_MODE_SELECT) begin
               staged_reg[curAddr[4:1]] <= {16'h0000, curVal};
            end
         end else if (curAddr == REG_COMMAND) begin
            cmd_reg <= curVal;
            cmdSeen_reg <= 1'b1;
         end else if (curAddr == REG_SERIAL_RATE) begin
            cfgStaged_reg.baudSel <= curVal[1:0];
            cfgStaged_reg.parity <= curVal[3:2] == 2'h3 ? PAR_NONE : curVal[3:2];
            cfgPend_reg <= 1'b1;
         end else if (curAddr == REG_DEVICE_ADDR) begin
            cfgStaged_reg.devAddr <= curVal[7:0];
            cfgPend_reg <= 1'b1;
         end
      end
   end

   // active setpoints follow staged ones only on their command
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         activeParam <= '0;
      end else if (applyEn) begin
         for (int s = 0; s < PARAM_COUNT; s++) begin
            if ((cmd_reg == CMD_BATTERY && MASK_BATTERY[s])
                || (cmd_reg == CMD_DYNAMIC && MASK_DYNAMIC[s])
                || (cmd_reg == CMD_SYSTEM && MASK_SYSTEM[s])) begin
               activeParam[s] <= staged_reg[s];
            end
         end
      end
   end

   // coils, selected function and load input
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         loadState <= '0;
         stagedEnable_reg <= 1'b0;
      end else if (state_reg == S_DECODE && frameOk && coilOk) begin
         if (startAddr == COIL_REMOTE_CTRL) loadState.remoteCtrl <= wordAt == COIL_ON;
         if (startAddr == COIL_REMOTE_ENABLE) stagedEnable_reg <= wordAt == COIL_ON;
      end else if (applyEn) begin
         if (cmd_reg == CMD_BATTERY || cmd_reg == CMD_DYNAMIC || cmd_reg == CMD_SYSTEM) begin
            loadState.function_ <= cmd_reg;
         end
         if (cmd_reg == CMD_SYSTEM) loadState.remoteEnable <= stagedEnable_reg;
         if (cmd_reg == CMD_INPUT_ON) loadState.loadOn <= 1'b1;
         if (cmd_reg == CMD_INPUT_OFF) loadState.loadOn <= 1'b0;
      end
   end

   // serial setup: local writes, remote change after the reply
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         serialCfg <= CFG_RESET;
      end else if (cfgApply && cfgPend_reg) begin
         serialCfg <= cfgStaged_reg;
      end else if (regWrite && regAddr == OFS_CONFIG) begin
         serialCfg <= serial_cfg_s'(regWdata[11:0]);
      end
   end

   // counter of frames with bad characters or a bad check sum
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         errors_reg <= 32'h0000_0000;
      end else if (state_reg == S_DECODE && (bad_reg || crc_reg != 16'h0000)) begin
         errors_reg <= errors_reg + 32'h0000_0001;
      end
   end

   // local read port, data in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         regRdata <= 32'h0000_0000;
      end else if (regRead) begin
         if (regAddr == OFS_CONFIG) regRdata <= {20'h0_0000, serialCfg};
         else if (regAddr == OFS_STATUS) regRdata <= {13'h0000, loadState};
         else if (regAddr == OFS_ERRORS) regRdata <= errors_reg;
         else if (regAddr >= OFS_PARAM_BASE && regAddr < OFS_PARAM_BASE + 8'(4 * PARAM_COUNT)
                  && regAddr[1:0] == 2'h0) regRdata <= activeParam[4'(regAddr[5:2])];
         else regRdata <= 32'h0000_0000;
      end else begin
         regRdata <= 32'h0000_0000;
      end
   end
endmodule // load_remote_command_port

// ==== design/load_remote_pkg.sv ====
// shared constants, types and helpers of the remote command port
package load_remote_pkg;
   localparam int CLK_HZ = 250_000_000;
   // serial rate selections
   localparam logic [1:0] BAUD_4800 = 2'h0;
   localparam logic [1:0] BAUD_9600 = 2'h1;
   localparam logic [1:0] BAUD_19200 = 2'h2;
   localparam logic [1:0] BAUD_38400 = 2'h3;
   // parity selections
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_ODD = 2'h2;
   localparam int DATA_BITS = 8;
   localparam int GAP_BITS = 35;
   localparam int RX_BUF_BYTES = 24;
   localparam int MAX_PRESET_REGS = 8;
   // frame function codes, coil addresses and values
   localparam logic [7:0] FN_FORCE_COIL = 8'h05;
   localparam logic [7:0] FN_PRESET_MULTI = 8'h10;
   localparam logic [15:0] COIL_REMOTE_CTRL = 16'h0000;
   localparam logic [15:0] COIL_REMOTE_ENABLE = 16'h0001;
   localparam logic [15:0] COIL_ON = 16'hFF00;
   localparam logic [15:0] COIL_OFF = 16'h0000;
   // parameter slots, two 16-bit registers each, high word at even address
   localparam int PARAM_COUNT = 12;
   localparam logic [3:0] SLOT_MODE_SELECT = 4'h8;
   localparam logic [15:0] MAX_MODE_SELECT = 16'h0002;
   localparam logic [15:0] REG_PARAM_END = 16'h0018;
   localparam logic [15:0] REG_COMMAND = 16'h0018;
   localparam logic [15:0] REG_SERIAL_RATE = 16'h001A;
   localparam logic [15:0] REG_DEVICE_ADDR = 16'h001B;
   // command codes
   localparam logic [15:0] CMD_DYNAMIC = 16'h0019;
   localparam logic [15:0] CMD_BATTERY = 16'h0026;
   localparam logic [15:0] CMD_SYSTEM = 16'h0029;
   localparam logic [15:0] CMD_INPUT_ON = 16'h002A;
   localparam logic [15:0] CMD_INPUT_OFF = 16'h002B;
   localparam logic [11:0] MASK_BATTERY = 12'h003;
   localparam logic [11:0] MASK_DYNAMIC = 12'h1FC;
   localparam logic [11:0] MASK_SYSTEM = 12'hE00;
   // local register offsets
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ERRORS = 8'h08;
   localparam logic [7:0] OFS_PARAM_BASE = 8'h40;

   typedef struct packed {
      logic [7:0] devAddr;
      logic [1:0] parity;
      logic [1:0] baudSel;
   } serial_cfg_s;
   localparam serial_cfg_s CFG_RESET = '{devAddr: 8'h01, parity: PAR_NONE, baudSel: BAUD_9600};

   typedef struct packed {
      logic [15:0] function_;
      logic remoteCtrl;
      logic remoteEnable;
      logic loadOn;
   } load_state_s;

   // clock cycles per serial bit for a rate selection
   function automatic logic [15:0] bit_ticks(input logic [1:0] sel, input int hz);
      case (sel)
         BAUD_4800: bit_ticks = 16'(hz / 4800);
         BAUD_19200: bit_ticks = 16'(hz / 19200);
         BAUD_38400: bit_ticks = 16'(hz / 38400);
         default: bit_ticks = 16'(hz / 9600);
      endcase
   endfunction

   // parity bit to send or expect for a byte
   function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] mode);
      parity_bit = (mode == PAR_ODD) ? ~(^d) : ^d;
   endfunction

   // one byte step of the frame check sum
   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] d);
      logic [15:0] c;
      c = crc ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
      end
      crc_step = c;
   endfunction
endpackage

// ==== design/uart_rx_unit.sv ====
// serial character receiver with parity and stop check
`timescale 1ns/1ps
module uart_rx_unit (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // line and setup
   input wire logic rxLine,
   input wire logic [15:0] bitTicks,
   input wire logic [1:0] parity,
   // received character
   output logic byteValid,
   output logic [7:0] byteData,
   output logic byteError
);
   import load_remote_pkg::*;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;
   rx_state_e state_reg;
   logic [15:0] tick_reg;
   logic [2:0] bitIdx_reg;
   logic parErr_reg;

   // bit timing, sampled at mid bit
   always_ff @(posedge ref_clk) begin
      byteValid <= 1'b0;
      if (!resetn) begin
         state_reg <= RX_IDLE;
         tick_reg <= 16'h0000;
         bitIdx_reg <= 3'h0;
         parErr_reg <= 1'b0;
         byteData <= 8'h00;
         byteError <= 1'b0;
      end else if (state_reg == RX_IDLE) begin
         if (!rxLine) begin
            state_reg <= RX_START;
            tick_reg <= bitTicks >> 1;
         end
      end else if (tick_reg != 16'h0000) begin
         tick_reg <= tick_reg - 16'h0001;
      end else begin
         tick_reg <= bitTicks - 16'h0001;
         unique case (state_reg)
            RX_START: begin
               state_reg <= rxLine ? RX_IDLE : RX_DATA;
               bitIdx_reg <= 3'h0;
               parErr_reg <= 1'b0;
            end
            RX_DATA: begin
               byteData <= {rxLine, byteData[7:1]};
               bitIdx_reg <= bitIdx_reg + 3'h1;
               if (bitIdx_reg == 3'(DATA_BITS - 1)) begin
                  state_reg <= (parity == PAR_NONE) ? RX_STOP : RX_PARITY;
               end
            end
            RX_PARITY: begin
               parErr_reg <= rxLine != parity_bit(byteData, parity);
               state_reg <= RX_STOP;
            end
            RX_STOP: begin
               byteValid <= 1'b1;
               byteError <= parErr_reg | ~rxLine;
               state_reg <= RX_IDLE;
            end
            default: state_reg <= RX_IDLE;
         endcase
      end
   end
endmodule // uart_rx_unit

// ==== design/uart_tx_unit.sv ====
// serial character transmitter, 8 data bits, optional parity, 1 stop bit
`timescale 1ns/1ps
module uart_tx_unit (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // character to send
   input wire logic txStart,
   input wire logic [7:0] txData,
   output logic txReady,
   // setup and line
   input wire logic [15:0] bitTicks,
   input wire logic [1:0] parity,
   output logic txLine
);
   import load_remote_pkg::*;
   logic [10:0] shift_reg;
   logic [3:0] bitsLeft_reg;
   logic [15:0] tick_reg;

   assign txReady = (bitsLeft_reg == 4'h0);

   // shift out start, data, parity and stop bits
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         shift_reg <= 11'h7FF;
         bitsLeft_reg <= 4'h0;
         tick_reg <= 16'h0000;
         txLine <= 1'b1;
      end else if (txReady) begin
         txLine <= 1'b1;
         if (txStart) begin
            shift_reg <= (parity == PAR_NONE) ? {2'b11, txData, 1'b0}
                       : {1'b1, parity_bit(txData, parity), txData, 1'b0};
            bitsLeft_reg <= (parity == PAR_NONE) ? 4'hB : 4'hC;
            tick_reg <= 16'h0000;
         end
      end else if (tick_reg != 16'h0000) begin
         tick_reg <= tick_reg - 16'h0001;
      end else begin
         txLine <= shift_reg[0];
         shift_reg <= {1'b1, shift_reg[10:1]};
         bitsLeft_reg <= bitsLeft_reg - 4'h1;
         tick_reg <= bitTicks - 16'h0001;
      end
   end
endmodule // uart_tx_unit

// ==== sim/load_remote_chk.sv ====
// concurrent checks on the ports of the remote command port
`timescale 1ns/1ps
module load_remote_chk import load_remote_pkg::*; (
   // clock and reset
   input wire logic ref_clk,
   input wire logic resetn,
   // serial pins
   input wire logic rxdPin,
   input wire logic txdPin,
   // local register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   // state toward the load
   input wire logic [PARAM_COUNT-1:0][31:0] activeParam,
   input wire load_remote_pkg::load_state_s loadState,
   input wire load_remote_pkg::serial_cfg_s serialCfg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // read data only in the cycle after a read strobe
   chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 32'h0000_0000)
      else $error("read data outside its cycle");
   chk_cfg_read: assert property (regRead && regAddr == OFS_CONFIG |=>
      regRdata == {20'h0_0000, $past(serialCfg)}) else $error("config read wrong");
   chk_status_read: assert property (regRead && regAddr == OFS_STATUS |=>
      regRdata == {13'h0000, $past(loadState)}) else $error("status read wrong");
   chk_cfg_write: assert property (regWrite && regAddr == OFS_CONFIG |=>
      serialCfg == $past(regWdata[11:0])) else $error("config write lost");
   chk_misaligned_read: assert property (regRead && regAddr[1:0] != 2'h0 |=>
      regRdata == 32'h0000_0000) else $error("misaligned read not zero");
   // applied values move only with their own command
   chk_battery_apply: assert property ($changed(activeParam[0]) |->
      ##[0:3] loadState.function_ == CMD_BATTERY) else $error("setpoint moved");
   chk_dynamic_apply: assert property ($changed(activeParam[8]) |->
      ##[0:3] loadState.function_ == CMD_DYNAMIC) else $error("mode moved");
   chk_mode_range: assert property (activeParam[8] <= 32'(MAX_MODE_SELECT))
      else $error("mode select out of range");
   chk_enable_apply: assert property ($changed(loadState.remoteEnable) |->
      ##[0:3] loadState.function_ == CMD_SYSTEM) else $error("enable moved");
   chk_limit_apply: assert property ($changed(activeParam[9]) |->
      ##[0:3] loadState.function_ == CMD_SYSTEM) else $error("limit moved");
endmodule // load_remote_chk

bind load_remote_command_port load_remote_chk load_remote_chk_inst (.ref_clk, .resetn,
   .rxdPin, .txdPin, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .activeParam,
   .loadState, .serialCfg);

// ==== sim/host_model.sv ====
// host side of the serial link: frame sender and reply collector
`timescale 1ns/1ps
module host_model (
   // clock
   input wire logic ref_clk,
   // line and setup
   input wire logic rxLine,
   input wire logic [1:0] parity,
   input wire logic [15:0] bitTicks,
   output logic txLine
);
   logic [7:0] rxq[$];
   logic [7:0] rxByte;
   initial txLine = 1'b1;
   // one bit time on the line, changed just after an edge
   task automatic put_bit(input logic b);
      txLine <= b;
      repeat (bitTicks) @(posedge ref_clk);
   endtask
   // send a frame with its check sum, low byte first
   task automatic send_frame(input logic [7:0] f[$]);
      logic [15:0] crc;
      crc = 16'hFFFF;
      foreach (f[i]) begin
         crc = crc ^ {8'h00, f[i]};
         for (int k = 0; k < 8; k++) begin
            crc = crc[0] ? ((crc >> 1) ^ 16'hA001) : (crc >> 1);
         end
      end
      f.push_back(crc[7:0]);
      f.push_back(crc[15:8]);
      @(posedge ref_clk);
      foreach (f[i]) begin
         put_bit(1'b0);
         for (int j = 0; j < 8; j++) put_bit(f[i][j]);
         if (parity != 2'h0) put_bit(parity == 2'h2 ? ~(^f[i]) : ^f[i]);
         put_bit(1'b1);
      end
   endtask
   // collect reply characters at the agreed rate, sampled mid bit
   always begin
      @(negedge rxLine);
      repeat (bitTicks / 2) @(posedge ref_clk);
      for (int j = 0; j < 8; j++) begin
         repeat (bitTicks) @(posedge ref_clk);
         rxByte[j] = rxLine;
      end
      repeat (bitTicks * ((parity != 2'h0) ? 2 : 1)) @(posedge ref_clk);
      rxq.push_back(rxByte);
   end
endmodule // host_model

// ==== sim/tb_top.sv ====
// self-checking bench of the remote command port
`timescale 1ns/1ps
module tb_top;
   import load_remote_pkg::*;
   localparam int BT = 384_000 / 38400;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic rxdPin, txdPin;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0000_0000;
   logic [31:0] regRdata, rd, val;
   logic [PARAM_COUNT-1:0][31:0] activeParam;
   load_state_s loadState;
   serial_cfg_s serialCfg;
   logic [7:0] devA;
   logic [31:0] seed = 32'h0000_CC02;
   int num_errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   // clock and hang guard
   always #2 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 90_000) begin
         num_errors++;
         finish_test();
      end
   end
   load_remote_command_port #(.CLK_FREQ(384_000)) load_remote_command_port_inst (.ref_clk,
      .resetn, .rxdPin, .txdPin, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
      .activeParam, .loadState, .serialCfg);
   host_model host_model_inst (.ref_clk, .rxLine(txdPin), .parity(PAR_EVEN),
      .bitTicks(16'(BT)), .txLine(rxdPin));
   // next random value
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // register port cycles
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1 d = regRdata;
   endtask
   // one frame and its echo, or its silence
   task automatic xfer(input logic [7:0] f[$], input bit answered);
      int n;
      host_model_inst.rxq.delete();
      host_model_inst.send_frame(f);
      n = 0;
      while (host_model_inst.rxq.size() < 8 && n < 160 * BT) begin
         @(posedge ref_clk);
         n++;
      end
      repeat (2 * BT) @(posedge ref_clk);
      cmp_word("reply count", answered ? 8 : 0, 32'(host_model_inst.rxq.size()));
      for (int i = 0; i < 6 && answered; i++) begin
         cmp_byte("reply byte", f[i], host_model_inst.rxq[i]);
      end
   endtask
   task automatic preset(input logic [7:0] a, input logic [15:0] start, input logic [31:0] w,
      input int n, input bit answered);
      logic [7:0] f[$];
      f = {a, FN_PRESET_MULTI, start[15:8], start[7:0], 8'h00, 8'(n), 8'(2 * n)};
      if (n == 2) f = {f, w[31:24], w[23:16]};
      f = {f, w[15:8], w[7:0]};
      xfer(f, answered);
   endtask
   task automatic cmd(input logic [7:0] a, input logic [15:0] code, input bit answered);
      preset(a, REG_COMMAND, {16'h0000, code}, 1, answered);
   endtask
   task automatic coil(input logic [15:0] c, input logic [15:0] v);
      logic [7:0] f[$];
      f = {devA, FN_FORCE_COIL, c[15:8], c[7:0], v[15:8], v[7:0]};
      xfer(f, 1'b1);
   endtask
   // main sequence
   initial begin
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      #1;
      cmp_word("config after reset", 32'(CFG_RESET), 32'(serialCfg));
      cmp_word("state after reset", 32'h0000_0000, 32'(loadState));
      for (int b = 0; b < 4; b++) begin
         for (int p = 0; p < 3; p++) begin
            seed = lfsr(seed);
            reg_wr(OFS_CONFIG, {20'h0_0000, seed[7:0], 2'(p), 2'(b)});
            reg_rd(OFS_CONFIG, rd);
            cmp_word("config read", {20'h0_0000, seed[7:0], 2'(p), 2'(b)}, rd);
            cmp_word("config port", {20'h0_0000, seed[7:0], 2'(p), 2'(b)}, 32'(serialCfg));
         end
      end
      seed = lfsr(seed);
      devA = seed[7:0] | 8'h01;
      reg_wr(OFS_CONFIG, {20'h0_0000, devA, PAR_EVEN, BAUD_38400});
      reg_rd(8'h43, rd);
      cmp_word("unmapped read", 32'h0000_0000, rd);
      seed = lfsr(seed);
      val = seed;
      preset(devA, 16'h0000, val, 2, 1'b1);
      cmp_word("staged setpoint", 32'h0000_0000, activeParam[0]);
      cmd(devA, CMD_BATTERY, 1'b1);
      cmp_word("battery setpoint", val, activeParam[0]);
      cmp_word("battery function", 32'(CMD_BATTERY), 32'(loadState.function_));
      cmd(devA ^ 8'h80, CMD_INPUT_ON, 1'b0);
      cmp_word("foreign frame", 32'h0000_0000, 32'(loadState.loadOn));
      cmd(devA, CMD_INPUT_ON, 1'b1);
      reg_rd(OFS_STATUS, rd);
      cmp_word("status input on", {13'h0000, CMD_BATTERY, 3'b001}, rd);
      cmd(devA, CMD_INPUT_OFF, 1'b1);
      cmp_word("input off", 32'h0000_0000, 32'(loadState.loadOn));
      seed = lfsr(seed);
      preset(devA, 16'h0011, 32'(seed[1:0] % 3), 1, 1'b1);
      cmd(devA, CMD_DYNAMIC, 1'b1);
      cmp_word("mode select", 32'(seed[1:0] % 3), activeParam[8]);
      cmp_word("setpoint kept", val, activeParam[0]);
      coil(COIL_REMOTE_CTRL, COIL_ON);
      cmp_word("remote on", 32'h0000_0001, 32'(loadState.remoteCtrl));
      coil(COIL_REMOTE_CTRL, COIL_OFF);
      cmp_word("remote off", 32'h0000_0000, 32'(loadState.remoteCtrl));
      coil(COIL_REMOTE_ENABLE, COIL_ON);
      cmp_word("enable staged", 32'h0000_0000, 32'(loadState.remoteEnable));
      preset(devA, 16'h0012, val, 2, 1'b1);
      cmd(devA, CMD_SYSTEM, 1'b1);
      cmp_word("enable applied", 32'h0000_0001, 32'(loadState.remoteEnable));
      cmp_word("limit", val, activeParam[9]);
      finish_test();
   end
endmodule // tb_top
